// [nmcrc_gen.sv]
// Parity generator that appends 24 CRC bits to each navigation message.
// Notes on behaviour
// - Emit 24 parity bits per 276-bit message.
// - Zero seed at message start, forward order.
// - Divisor polynomial taps 0,1,3,4,5,6,7,10,11,14,17,18,23,24.
// - First information bit is highest power.
// - Parity is remainder of m(X)X^24 by g(X).
// - Parity bit i is remainder power 24-i.
// - Code catches every single flipped bit.
// - Code catches every double flipped bit.
// - Code catches every odd error count.
// - Code catches every burst up to 24 bits.
module nmcrc_gen
   import nmcrc_pkg::*;
#(
   parameter int unsigned INFO_BITS = NMCRC_INFO_BITS,
   parameter int unsigned PAR_W = NMCRC_PAR_W
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic in_valid,
   input wire logic in_data,
   output logic in_ready,
   output logic out_valid,
   output logic out_data,
   output logic out_parity,
   output logic out_last,
   output logic busy,
   output logic in_error
);
   initial begin
      if (INFO_BITS < 1 || INFO_BITS >= (1 << NMCRC_CNT_W)) begin
         $error("nmcrc_gen: INFO_BITS out of counter range");
      end
      if (PAR_W != NMCRC_PAR_W) begin
         $error("nmcrc_gen: PAR_W must match the polynomial width");
      end
   end

   localparam logic [NMCRC_CNT_W-1:0] LAST_INFO =
      NMCRC_CNT_W'(INFO_BITS - 1);
   localparam logic [NMCRC_CNT_W-1:0] LAST_PAR = NMCRC_CNT_W'(PAR_W - 1);

   nmcrc_state_e state_q;
   nmcrc_state_e state_d;
   logic [NMCRC_CNT_W-1:0] cnt_q;
   logic [NMCRC_CNT_W-1:0] cnt_d;
   nmcrc_bit_s out_q;
   nmcrc_bit_s out_d;
   logic par_q;
   logic err_q;
   logic [PAR_W-1:0] rem;

   wire logic take = in_valid && in_ready;
   wire logic in_idle = (state_q == NMCRC_IDLE);
   wire logic in_info = (state_q == NMCRC_INFO);
   wire logic in_par = (state_q == NMCRC_PAR);
   wire logic info_done = in_info && (cnt_q == LAST_INFO);
   wire logic par_done = in_par && (cnt_q == LAST_PAR);
   // Input is held off during parity so no information bit can slip in.
   assign in_ready = !in_par;

   nmcrc_lfsr #(
      .WIDTH(PAR_W),
      .POLY(NMCRC_POLY[PAR_W-1:0])
   ) u_lfsr (
      .clock(clock),
      .srst(srst),
      .clear(in_idle),
      .step(take),
      .din(in_data),
      .shift_out(in_par),
      .rem(rem)
   );

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         NMCRC_IDLE: begin
            if (take) begin
               state_d = (INFO_BITS == 1) ? NMCRC_PAR : NMCRC_INFO;
               cnt_d = (INFO_BITS == 1) ? '0 : NMCRC_CNT_W'(1);
            end
         end
         NMCRC_INFO: begin
            if (take) begin
               if (info_done) begin
                  state_d = NMCRC_PAR;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + NMCRC_CNT_W'(1);
               end
            end
         end
         NMCRC_PAR: begin
            if (par_done) begin
               state_d = NMCRC_IDLE;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + NMCRC_CNT_W'(1);
            end
         end
      endcase
   end

   // Parity leaves the top of the remainder first, power 23 down to 0.
   always_comb begin
      out_d = '0;
      if (in_par) begin
         out_d.valid = 1'b1;
         out_d.data = rem[PAR_W-1];
         out_d.last = par_done;
      end else if (take) begin
         out_d.valid = 1'b1;
         out_d.data = in_data;
         out_d.first = in_idle;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= NMCRC_IDLE;
         cnt_q <= '0;
         out_q <= '0;
         par_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
         par_q <= in_par;
         err_q <= in_valid && in_par;
      end
   end

   assign out_valid = out_q.valid;
   assign out_data = out_q.data;
   assign out_parity = par_q;
   assign out_last = out_q.last;
   assign busy = !in_idle;
   assign in_error = err_q;
endmodule

// [nmcrc_pkg.sv]
// Package with constants and carrier types for the message parity unit.
package nmcrc_pkg;
   localparam int unsigned NMCRC_PAR_W = 24;
   localparam int unsigned NMCRC_INFO_BITS = 276;
   localparam logic [23:0] NMCRC_POLY = 24'h864CFB;
   localparam logic [23:0] NMCRC_SEED = 24'h000000;
   localparam int unsigned NMCRC_CNT_W = 9;

   typedef enum logic [1:0] {
      NMCRC_IDLE,
      NMCRC_INFO,
      NMCRC_PAR
   } nmcrc_state_e;

   typedef struct packed {
      logic valid;
      logic data;
      logic first;
      logic last;
   } nmcrc_bit_s;
endpackage

// [nmcrc_lfsr.sv]
// One-bit-per-cycle CRC remainder register for the message parity unit.
module nmcrc_lfsr
   import nmcrc_pkg::*;
#(
   parameter int unsigned WIDTH = NMCRC_PAR_W,
   parameter logic [WIDTH-1:0] POLY = NMCRC_POLY
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic clear,
   input wire logic step,
   input wire logic din,
   input wire logic shift_out,
   output logic [WIDTH-1:0] rem
);
   initial begin
      if (WIDTH < 2 || WIDTH > NMCRC_PAR_W) begin
         $error("nmcrc_lfsr: WIDTH must lie between 2 and the seed width");
      end
   end

   logic [WIDTH-1:0] rem_q;
   logic [WIDTH-1:0] rem_d;
   wire logic fb = rem_q[WIDTH-1] ^ din;
   wire logic [WIDTH-1:0] rem_div = {rem_q[WIDTH-2:0], 1'b0} ^
      (fb ? POLY : '0);
   wire logic [WIDTH-1:0] rem_sh = {rem_q[WIDTH-2:0], 1'b0};

   // Clear with step loads the seed and absorbs the first bit in one cycle.
   assign rem_d = shift_out ? rem_sh :
      (clear ? (step ? ({WIDTH{din}} & POLY) : NMCRC_SEED[WIDTH-1:0]) :
      (step ? rem_div : rem_q));

   always_ff @(posedge clock) begin
      if (srst) begin
         rem_q <= NMCRC_SEED[WIDTH-1:0];
      end else begin
         rem_q <= rem_d;
      end
   end

   assign rem = rem_q;
endmodule

// [nmcrc_gen_chk.sv]
// Port timing checker for the parity generator.
module nmcrc_gen_chk (
   input logic clock,
   input logic srst,
   input logic in_valid,
   input logic in_data,
   input logic in_ready,
   input logic out_valid,
   input logic out_data,
   input logic out_parity,
   input logic out_last,
   input logic in_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   a_echo_info: assert property (
      in_valid && in_ready |=> out_valid && out_data == $past(in_data))
      else $error("no echo");
   a_par_start: assert property ($fell(in_ready) |=> out_parity)
      else $error("late parity");
   a_gap_free: assert property (out_parity && !out_last |=> out_parity)
      else $error("parity gap");
   a_par_count: assert property (
      out_last |-> $past(out_parity, 23) && !$past(out_parity, 24))
      else $error("parity count");
   a_ready_back: assert property (out_last |-> in_ready)
      else $error("not ready");
   a_refuse_err: assert property (in_valid && !in_ready |=> in_error)
      else $error("no refusal");
   a_ready_low: assert property (
      out_parity && !out_last |-> !in_ready)
      else $error("open in parity");
   a_quiet_out: assert property (!out_valid |-> !out_parity)
      else $error("stray parity");
   c_last: cover property (out_last);
   c_err: cover property (in_error);
   c_par: cover property ($rose(out_parity));
endmodule
bind nmcrc_gen nmcrc_gen_chk nmcrc_gen_chk_inst (.*);

// [nmcrc_rx.sv]
// Receiver model that divides each whole codeword by the generator.
module nmcrc_rx
   import nmcrc_pkg::*;
(
   input logic clock,
   input logic srst,
   input logic v,
   input logic d,
   input logic last,
   output logic bad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] rem_q;
   wire [23:0] rem_d = {rem_q[22:0], 1'b0} ^
      ((rem_q[23] ^ d) ? NMCRC_POLY : 24'h000000);
   // Parity included, a clean codeword leaves a zero remainder.
   always_ff @(posedge clock) begin
      bad <= !srst && v && last && rem_d != 24'h000000;
      if (srst || (v && last)) rem_q <= NMCRC_SEED;
      else if (v) rem_q <= rem_d;
   end
endmodule

// [tb_nmcrc_gen.sv]
// Bench for the message parity generator.
module tb_nmcrc_gen;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [31:0] pat;
      logic [8:0] pos;
      logic [24:0] flip;
      logic extra;
   } nmcrc_row_s;
   // Every flip mask here must be caught; the last row stays clean.
   localparam nmcrc_row_s ROWS [6] = '{
      '{32'hA5C30F1E, 9'h000, 25'h0000001, 1'b0},
      '{32'h12345678, 9'h122, 25'h0000001, 1'b1},
      '{32'hFFFFFFFF, 9'h00A, 25'h1000001, 1'b0},
      '{32'h0F0F0F0F, 9'h064, 25'h0000007, 1'b0},
      '{32'hDEADBEEF, 9'h114, 25'h0FFFFFF, 1'b0},
      '{32'hC3000001, 9'h000, 25'h0000000, 1'b0}};
   logic clock = 1'b0, srst = 1'b1, in_valid = 1'b0, in_data = 1'b0;
   logic in_ready, out_valid, out_data, out_parity, out_last, busy, in_error;
   logic bad, fb;
   logic cw [300];
   nmcrc_row_s cur;
   int n_fail = 0, n_tests = 0, i = 0;
   nmcrc_gen nmcrc_gen_inst (.clock(clock), .srst(srst), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
      .out_data(out_data), .out_parity(out_parity), .out_last(out_last),
      .busy(busy), .in_error(in_error));
   nmcrc_rx nmcrc_rx_inst (.clock(clock), .srst(srst), .v(out_valid),
      .d(out_data ^ fb), .last(out_last), .bad(bad));
   initial forever #4 clock = ~clock;
   task chk(input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask
   task end_of_test();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task send(input nmcrc_row_s r);
      logic [23:0] q;
      q = 24'h000000;
      cur = r;
      for (int k = 0; k < 276; k++) begin
         cw[k] = r.pat[k % 32];
         q = {q[22:0], 1'b0} ^
            ((q[23] ^ cw[k]) ? 24'h864CFB : 24'h000000);
      end
      for (int k = 0; k < 24; k++) cw[276 + k] = q[23 - k];
      for (int k = 0; k < 276 + r.extra; k++) begin
         @(posedge clock);
         in_valid <= 1'b1;
         in_data <= cw[k % 276];
      end
      @(posedge clock);
      in_valid <= 1'b0;
      @(negedge clock);
      chk(in_error, r.extra);
      for (int w = 0; w < 40 && out_last !== 1'b1; w++) @(negedge clock);
      @(negedge clock);
      chk(bad, |r.flip);
   endtask
   always @(negedge clock) begin
      if (srst) i = 0;
      else if (out_valid === 1'b1) begin
         chk(out_data, cw[i]);
         chk(out_parity, i > 275);
         chk(out_last, i == 299);
         chk(busy, i != 299);
         chk(in_ready, i < 275 || i == 299);
         fb = i >= cur.pos && i - cur.pos < 25 && cur.flip[i - cur.pos];
         i = out_last ? 0 : i + 1;
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      foreach (ROWS[r]) send(ROWS[r]);
      // A message cut by reset must carry real codeword bits for the monitor.
      for (int k = 0; k < 5; k++) begin
         @(posedge clock);
         in_valid <= 1'b1;
         in_data <= cw[k];
      end
      @(posedge clock);
      srst <= 1'b1;
      in_valid <= 1'b0;
      @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      chk({out_valid, out_parity, out_last, in_error, busy}, 5'h00);
      chk(in_ready, 1'b1);
      send(ROWS[5]);
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
endmodule
